// [logic/mmd_decoder.sv]
// cpu memory map decoder: program counter, data space decode, response mux
//
// Behaviour
// R1: program and data are separate spaces; data uses eight-bit addresses.
// R2: program memory is read only, at most 62 kbytes on chip.
// R3: after any reset instruction fetch starts at program address zero.
// R4: accepted interrupt loads its fixed vector into the program counter.
// R5: vectors sit eight bytes apart starting at 0003h.
// R6: data addresses 00h to 7fh reach lower internal ram.
// R7: indirect accesses to 80h to ffh reach upper ram, never sfrs.
// R8: direct accesses to 80h to ffh reach sfrs; of the other modes only bit accesses do.
// R9: 16384 bytes of aux ram at 0000h to 3fffh, reached only by aux moves.
// R10: lowest 32 bytes form four banks of eight registers.
// R11: two bank select bits of the status byte pick the bank.
// R12: bytes 20h to 2fh are bit addresses 00h to 7fh.
// R13: only sfrs at addresses ending 0h or 8h are bit addressable.
// R14: bit addresses 80h to ffh select bits inside those sfrs.
// R15: unimplemented sfr reads return zero; writes to them do nothing.
`timescale 1ns/100ps
`default_nettype none

module mmd_decoder
   import mmd_pkg::*;
#(
   parameter int unsigned IRQ_W      = 3,
   parameter int unsigned PROG_SIZE  = PROG_BYTES,
   parameter int unsigned AUX_SIZE   = AUX_BYTES
)
(
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   // program counter control
   input  wire logic             fetch_i,
   input  wire logic             pc_load_i,
   input  wire logic [15:0]      pc_load_val_i,
   input  wire logic             irq_accept_i,
   input  wire logic [IRQ_W-1:0] irq_num_i,
   output logic      [15:0]      pc_o,
   // program memory read port
   output logic                  prog_rd_o,
   output logic      [15:0]      prog_addr_o,
   input  wire logic [7:0]       prog_rdata_i,
   output logic                  instr_valid_o,
   output logic      [7:0]       instr_o,
   output logic                  instr_err_o,
   // data request from the cpu
   input  wire logic             req_valid_i,
   input  wire mmd_req_t         req_i,
   input  wire logic [7:0]       status_byte_i,
   // memory and sfr strobes
   output mmd_port_t             iram_port_o,
   output mmd_port_t             sfr_port_o,
   output mmd_port_t             aux_port_o,
   input  wire logic [7:0]       iram_rdata_i,
   input  wire logic [7:0]       sfr_rdata_i,
   input  wire logic             sfr_hit_i,
   input  wire logic [7:0]       aux_rdata_i,
   // response to the cpu
   output logic                  rsp_valid_o,
   output logic      [7:0]       rsp_data_o,
   output logic                  rsp_bit_o,
   output logic                  rsp_err_o
);

   // ---------------- program counter ----------------
   logic [15:0] pc_ff;
   logic [15:0] nxt_pc;
   logic [15:0] irq_vector;
   logic        prog_rd_ff;
   logic [15:0] prog_addr_ff;
   logic        instr_valid_ff;
   logic [7:0]  instr_ff;
   logic        instr_err_ff;
   logic        prog_in_range;

   // vector is base plus eight times the source number
   assign irq_vector = VEC_BASE + (16'(irq_num_i) << VEC_SHIFT);          // R5
   // interrupt beats a jump, a jump beats the sequential step
   assign nxt_pc = irq_accept_i ? irq_vector :                           // R4
                   pc_load_i    ? pc_load_val_i :
                   fetch_i      ? pc_ff + 16'h0001 :
                                  pc_ff;

   // pc register
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pc_ff <= RESET_PC;                                              // R3
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // fetch strobe: read only, the block has no write path into code
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prog_rd_ff   <= 1'b0;
         prog_addr_ff <= RESET_PC;
      end else begin
         prog_rd_ff   <= fetch_i;                                        // R2
         prog_addr_ff <= pc_ff;
      end
   end

   // beyond the on-chip size a fetch yields zero and an error flag
   assign prog_in_range = (32'(prog_addr_ff) < PROG_SIZE);               // R2

   // fetched byte back to the pipeline
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         instr_valid_ff <= 1'b0;
         instr_ff       <= ZERO_BYTE;
         instr_err_ff   <= 1'b0;
      end else begin
         instr_valid_ff <= prog_rd_ff;
         instr_ff       <= (prog_rd_ff && prog_in_range) ? prog_rdata_i : ZERO_BYTE;
         instr_err_ff   <= prog_rd_ff && !prog_in_range;
      end
   end

   assign pc_o          = pc_ff;
   assign prog_rd_o     = prog_rd_ff;
   assign prog_addr_o   = prog_addr_ff;
   assign instr_valid_o = instr_valid_ff;
   assign instr_o       = instr_ff;
   assign instr_err_o   = instr_err_ff;

   // ---------------- data space decode ----------------
   logic [7:0] low_addr;
   logic [1:0] bank_sel;
   logic [7:0] reg_addr;
   logic [7:0] bit_byte;
   logic [2:0] bit_idx;
   logic [7:0] bit_mask;
   logic       bit_is_sfr;
   logic       k_direct;
   logic       k_indirect;
   logic       k_reg;
   logic       k_bit;
   logic       k_aux;
   logic       hit_iram;
   logic       hit_sfr;
   logic       hit_aux;
   logic       hit_err;
   logic [7:0] dec_addr;
   logic [7:0] dec_wdata;
   logic [7:0] dec_mask;

   // data spaces look at the low byte only; aux uses the full word
   assign low_addr = req_i.addr[7:0];                                    // R1

   // bank select from the status byte
   assign bank_sel = {status_byte_i[BANK_HI_POS], status_byte_i[BANK_LO_POS]}; // R11
   assign reg_addr = {3'b000, bank_sel, low_addr[2:0]};                  // R10

   // bit address split
   mmd_bit_addr u_bit_addr (
      .bit_addr_i  (low_addr),
      .byte_addr_o (bit_byte),
      .bit_idx_o   (bit_idx),
      .bit_mask_o  (bit_mask),
      .is_sfr_o    (bit_is_sfr)
   );

   // mode decode
   assign k_direct   = req_valid_i && (req_i.kind == MMD_AK_DIRECT);
   assign k_indirect = req_valid_i && (req_i.kind == MMD_AK_INDIRECT);
   assign k_reg      = req_valid_i && (req_i.kind == MMD_AK_REG);
   assign k_bit      = req_valid_i && (req_i.kind == MMD_AK_BIT);
   assign k_aux      = req_valid_i && (req_i.kind == MMD_AK_AUX);

   // space select: upper half splits on the addressing mode
   assign hit_sfr  = (k_direct && (low_addr > LOW_RAM_TOP))              // R8
                   || (k_bit && bit_is_sfr);                             // R14
   assign hit_iram = (k_direct && (low_addr <= LOW_RAM_TOP))             // R6
                   || k_indirect                                         // R7
                   || k_reg
                   || (k_bit && !bit_is_sfr);                            // R12
   assign hit_aux  = k_aux && (32'(req_i.addr) < AUX_SIZE);              // R9
   // no off-chip bus here, so aux beyond the array is an error
   assign hit_err  = k_aux && !hit_aux;

   // address, data and lane mask for the selected byte
   assign dec_addr  = k_reg ? reg_addr :
                      k_bit ? bit_byte :
                              low_addr;
   // a bit write carries its value in wdata bit 0 on every lane
   assign dec_wdata = k_bit ? {8{req_i.wdata[0]}} : req_i.wdata;
   assign dec_mask  = k_bit ? bit_mask : MASK_BYTE;

   // ---------------- strobe stage ----------------
   mmd_port_t iram_ff;
   mmd_port_t sfr_ff;
   mmd_port_t aux_ff;
   mmd_port_t nxt_iram;
   mmd_port_t nxt_sfr;
   mmd_port_t nxt_aux;
   logic      stg_valid_ff;
   logic      stg_bit_ff;
   logic [2:0] stg_idx_ff;
   logic      stg_err_ff;

   // next strobes; only one space is ever selected per request
   assign nxt_iram = '{sel: hit_iram, we: hit_iram && req_i.we, addr: {8'h00, dec_addr},
                       wdata: dec_wdata, wmask: dec_mask};
   assign nxt_sfr  = '{sel: hit_sfr, we: hit_sfr && req_i.we, addr: {8'h00, dec_addr},
                       wdata: dec_wdata, wmask: dec_mask};
   assign nxt_aux  = '{sel: hit_aux, we: hit_aux && req_i.we, addr: req_i.addr,
                       wdata: req_i.wdata, wmask: MASK_BYTE};

   // strobes leave from flip-flops, one cycle after the request
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         iram_ff <= '0;
         sfr_ff  <= '0;
         aux_ff  <= '0;
      end else begin
         iram_ff <= nxt_iram;
         sfr_ff  <= nxt_sfr;
         aux_ff  <= nxt_aux;
      end
   end

   // request context travelling alongside the strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         stg_valid_ff <= 1'b0;
         stg_bit_ff   <= 1'b0;
         stg_idx_ff   <= 3'h0;
         stg_err_ff   <= 1'b0;
      end else begin
         stg_valid_ff <= req_valid_i;
         stg_bit_ff   <= k_bit;
         stg_idx_ff   <= bit_idx;
         stg_err_ff   <= hit_err;
      end
   end

   assign iram_port_o = iram_ff;
   assign sfr_port_o  = sfr_ff;
   assign aux_port_o  = aux_ff;

   // ---------------- response stage ----------------
   logic [7:0] sel_rdata;
   logic       rsp_valid_ff;
   logic [7:0] rsp_data_ff;
   logic       rsp_bit_ff;
   logic       rsp_err_ff;

   // arrays answer in the strobe cycle; a silent sfr address reads zero
   assign sel_rdata = iram_ff.sel ? iram_rdata_i :
                      (sfr_ff.sel && sfr_hit_i) ? sfr_rdata_i :          // R15
                      aux_ff.sel ? aux_rdata_i :
                                   ZERO_BYTE;

   // response registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rsp_valid_ff <= 1'b0;
         rsp_data_ff  <= ZERO_BYTE;
         rsp_bit_ff   <= 1'b0;
         rsp_err_ff   <= 1'b0;
      end else begin
         rsp_valid_ff <= stg_valid_ff;
         rsp_data_ff  <= sel_rdata;
         rsp_bit_ff   <= stg_bit_ff && sel_rdata[stg_idx_ff];
         rsp_err_ff   <= stg_err_ff;
      end
   end

   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_data_o  = rsp_data_ff;
   assign rsp_bit_o   = rsp_bit_ff;
   assign rsp_err_o   = rsp_err_ff;

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   AST_RESET_PC: assert property (                                       // R3
      $fell(reset_i) |-> (pc_ff == RESET_PC))
      else $error("pc not zero after reset");

   AST_IRQ_VECTOR: assert property (                                     // R4
      irq_accept_i |=> (pc_ff == VEC_BASE + (16'($past(irq_num_i)) << VEC_SHIFT)))
      else $error("interrupt vector not loaded");

   AST_VEC_SPACING: assert property (                                    // R5
      (irq_accept_i && irq_num_i == 1) |=> (pc_ff == 16'h000b))
      else $error("second vector not at 000bh");

   AST_FETCH_RO: assert property (                                       // R2
      fetch_i |=> (prog_rd_ff && prog_addr_ff == $past(pc_ff)) ##1
      (instr_valid_ff && (instr_err_ff == (32'($past(prog_addr_ff)) >= PROG_SIZE))))
      else $error("fetch strobe wrong");

   AST_LOW_RAM: assert property (                                        // R6
      (k_direct && low_addr <= LOW_RAM_TOP) |=>
      (iram_ff.sel && !sfr_ff.sel && iram_ff.addr[7:0] == $past(low_addr)))
      else $error("low ram decode wrong");

   AST_UPPER_IND: assert property (                                      // R7
      (k_indirect && low_addr > LOW_RAM_TOP) |=> (iram_ff.sel && !sfr_ff.sel))
      else $error("indirect upper access reached sfr");

   AST_SFR_DIRECT: assert property (                                     // R8
      sfr_ff.sel |-> ($past(k_direct) || ($past(k_bit) && $past(low_addr[7]))))
      else $error("sfr reached by a non-direct mode");

   AST_AUX_ONLY: assert property (                                       // R9
      (k_aux && req_i.addr < 16'h4000) |=> (aux_ff.sel && !iram_ff.sel && !sfr_ff.sel
      && aux_ff.addr == $past(req_i.addr)))
      else $error("aux ram decode wrong");

   AST_AUX_MODE: assert property (                                       // R1
      aux_ff.sel |-> $past(k_aux))
      else $error("aux ram reached by a data mode");

   AST_BANK: assert property (                                           // R11
      k_reg |=> (iram_ff.addr[7:0] == {3'b000, $past(status_byte_i[4]),
      $past(status_byte_i[3]), $past(low_addr[2:0])}))
      else $error("register bank mapping wrong");

   AST_BIT_RAM: assert property (                                        // R12
      (k_bit && !low_addr[7]) |=> (iram_ff.sel && $onehot(iram_ff.wmask)
      && iram_ff.addr[7:0] == 8'h20 + {4'h0, $past(low_addr[6:3])}))
      else $error("bit area decode wrong");

   AST_BIT_SFR: assert property (                                        // R13
      (k_bit && low_addr[7]) |=> (sfr_ff.sel && sfr_ff.addr[2:0] == 3'h0))
      else $error("bit access to a byte-only sfr");

   AST_SFR_ZERO: assert property (                                       // R15
      (sfr_ff.sel && !sfr_hit_i) |=> (rsp_valid_ff && rsp_data_ff == 8'h00))
      else $error("unimplemented sfr read not zero");

endmodule

`default_nettype wire

// [logic/mmd_pkg.sv]
// shared constants and types of the cpu memory map decoder
package mmd_pkg;

   // address widths
   localparam int unsigned DATA_AW = 8;
   localparam int unsigned WIDE_AW = 16;

   // internal data space
   localparam logic [7:0] LOW_RAM_TOP  = 8'h7f;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] BIT_SFR_MIN  = 8'h80;

   // register banks: four banks of eight, bank bits in the status byte
   localparam int unsigned BANK_REGS    = 8;
   localparam int unsigned BANK_COUNT   = 4;
   localparam int unsigned BANK_HI_POS  = 4;
   localparam int unsigned BANK_LO_POS  = 3;

   // program space and vectors
   localparam logic [15:0] RESET_PC    = 16'h0000;
   localparam logic [15:0] VEC_BASE    = 16'h0003;
   localparam int unsigned VEC_SHIFT   = 3;
   localparam int unsigned PROG_BYTES  = 63488;

   // auxiliary data ram
   localparam int unsigned AUX_BYTES   = 16384;

   // byte masks
   localparam logic [7:0] MASK_BYTE = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // addressing modes of a data request
   typedef enum logic [2:0] {
      MMD_AK_DIRECT,
      MMD_AK_INDIRECT,
      MMD_AK_REG,
      MMD_AK_BIT,
      MMD_AK_AUX
   } mmd_kind_t;

   // data request from the cpu pipeline
   typedef struct packed {
      mmd_kind_t   kind;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mmd_req_t;

   // strobe towards one memory or the sfr bus
   typedef struct packed {
      logic        sel;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  wmask;
   } mmd_port_t;

endpackage

// [logic/mmd_bit_addr.sv]
// splits a single-bit address into byte address, bit index and write mask
`timescale 1ns/100ps
`default_nettype none

module mmd_bit_addr
   import mmd_pkg::*;
(
   // bit address in
   input  wire logic [7:0] bit_addr_i,
   // decoded location
   output logic       [7:0] byte_addr_o,
   output logic       [2:0] bit_idx_o,
   output logic       [7:0] bit_mask_o,
   output logic             is_sfr_o
);

   // upper half lands on sfr bytes ending in 0h or 8h only
   assign is_sfr_o    = bit_addr_i[7];                                   // R14
   assign bit_idx_o   = bit_addr_i[2:0];
   assign byte_addr_o = is_sfr_o ? {bit_addr_i[7:3], 3'b000}             // R13
                                 : (BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]}); // R12

   // one-hot mask, one bit per lane
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_mask
         assign bit_mask_o[gi] = (bit_addr_i[2:0] == 3'(gi));
      end
   endgenerate

endmodule

`default_nettype wire

// [testbench/mmd_decoder_tb_top.sv]
// self-checking bench for the cpu memory map decoder
`timescale 1ns/100ps
`default_nettype none

module mmd_decoder_tb_top
   import mmd_pkg::*;
();
   // clock, reset and stimulus
   logic        mclk_i;
   logic        reset_i;
   logic        fetch_i;
   logic        pc_load_i;
   logic [15:0] pc_load_val_i;
   logic        irq_accept_i;
   logic [2:0]  irq_num_i;
   logic [7:0]  prog_rdata_i;
   logic        req_valid_i;
   mmd_req_t    req_i;
   logic [7:0]  status_byte_i;
   logic [7:0]  iram_rdata_i;
   logic [7:0]  sfr_rdata_i;
   logic        sfr_hit_i;
   logic [7:0]  aux_rdata_i;
   // observed outputs
   logic [15:0] pc_o;
   logic        prog_rd_o;
   logic [15:0] prog_addr_o;
   logic        instr_valid_o;
   logic [7:0]  instr_o;
   logic        instr_err_o;
   mmd_port_t   iram_port_o;
   mmd_port_t   sfr_port_o;
   mmd_port_t   aux_port_o;
   logic        rsp_valid_o;
   logic [7:0]  rsp_data_o;
   logic        rsp_bit_o;
   logic        rsp_err_o;
   int          err_total;
   int          n_checks;

   mmd_decoder #(.IRQ_W(3)) u_mmd_decoder (
      .mclk_i(mclk_i), .reset_i(reset_i), .fetch_i(fetch_i), .pc_load_i(pc_load_i),
      .pc_load_val_i(pc_load_val_i), .irq_accept_i(irq_accept_i), .irq_num_i(irq_num_i),
      .pc_o(pc_o), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
      .prog_rdata_i(prog_rdata_i), .instr_valid_o(instr_valid_o), .instr_o(instr_o),
      .instr_err_o(instr_err_o), .req_valid_i(req_valid_i), .req_i(req_i),
      .status_byte_i(status_byte_i), .iram_port_o(iram_port_o), .sfr_port_o(sfr_port_o),
      .aux_port_o(aux_port_o), .iram_rdata_i(iram_rdata_i), .sfr_rdata_i(sfr_rdata_i),
      .sfr_hit_i(sfr_hit_i), .aux_rdata_i(aux_rdata_i), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .rsp_bit_o(rsp_bit_o), .rsp_err_o(rsp_err_o));

   // 200 mhz clock
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   // one comparison; case inequality so an unknown never matches
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one data request; tgt 0 iram, 1 sfr, 2 aux, 3 none
   task automatic do_req(input mmd_kind_t k, input logic w, input logic [15:0] a,
                         input logic [7:0] d, input int tgt, input logic [15:0] ea,
                         input logic [7:0] em, input logic [7:0] rd, input logic hit,
                         input logic [7:0] erd, input logic ebit);
      mmd_port_t p;
      @(posedge mclk_i);
      req_valid_i <= 1'b1;
      req_i       <= mmd_req_t'{k, w, a, d};
      @(posedge mclk_i);
      req_valid_i <= 1'b0;
      // memories answer combinationally in the strobe cycle
      iram_rdata_i <= rd;
      sfr_rdata_i  <= rd;
      aux_rdata_i  <= rd;
      sfr_hit_i    <= hit;
      #1;
      chk("port_sel", 16'(4'b0001 << tgt) & 16'h0007,
          16'({aux_port_o.sel, sfr_port_o.sel, iram_port_o.sel}));
      p = (tgt == 0) ? iram_port_o : (tgt == 1) ? sfr_port_o : aux_port_o;
      if (tgt < 3) begin
         chk("port_addr", ea, p.addr);
         chk("port_we", 16'(w), 16'(p.we));
         if (w) begin
            chk("port_wmask", 16'(em), 16'(p.wmask));
            // a bit write spreads its value over every lane
            chk("port_wdata", 16'((k == MMD_AK_BIT) ? {8{d[0]}} : d), 16'(p.wdata));
         end
      end
      @(posedge mclk_i);
      #1;
      chk("rsp_valid", 16'h0001, 16'(rsp_valid_o));
      chk("rsp_err", 16'(tgt == 3), 16'(rsp_err_o));
      if (!w) begin
         chk("rsp_data", 16'(erd), 16'(rsp_data_o));
         chk("rsp_bit", 16'(ebit), 16'(rsp_bit_o));
      end
   endtask

   // jump to an address and fetch one byte there
   task automatic fetch_at(input logic [15:0] at, input logic [7:0] byt, input logic err);
      @(posedge mclk_i);
      pc_load_i     <= 1'b1;
      pc_load_val_i <= at;
      @(posedge mclk_i);
      pc_load_i <= 1'b0;
      fetch_i   <= 1'b1;
      @(posedge mclk_i);
      fetch_i <= 1'b0;
      prog_rdata_i <= byt;
      #1;
      chk("prog_rd", 16'h0001, 16'(prog_rd_o));
      chk("prog_addr", at, prog_addr_o);
      chk("pc_after_fetch", at + 16'h0001, pc_o);
      @(posedge mclk_i);
      #1;
      chk("instr_valid", 16'h0001, 16'(instr_valid_o));
      chk("instr", err ? 16'h0000 : 16'(byt), 16'(instr_o));
      chk("instr_err", 16'(err), 16'(instr_err_o));
   endtask

   // every vector sits eight bytes above the previous; irq beats a jump
   task automatic t_vectors();
      for (int n = 0; n < 8; n++) begin
         @(posedge mclk_i);
         irq_accept_i  <= 1'b1;
         irq_num_i     <= 3'(n);
         pc_load_i     <= (n == 3);
         pc_load_val_i <= 16'h1234;
         @(posedge mclk_i);
         irq_accept_i <= 1'b0;
         pc_load_i    <= 1'b0;
         #1;
         chk("vector_pc", 16'h0003 + 16'(8 * n), pc_o);
      end
   endtask

   // reset in mid-run, then fetch in the first cycle after release
   task automatic t_reset();
      @(posedge mclk_i);
      reset_i <= 1'b1;
      fetch_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      #1;
      chk("pc_in_reset", 16'h0000, pc_o);
      chk("rsp_valid_reset", 16'h0000, 16'(rsp_valid_o));
      @(posedge mclk_i);
      fetch_i <= 1'b0;
      #1;
      chk("first_fetch_addr", 16'h0000, prog_addr_o);
      chk("first_fetch_rd", 16'h0001, 16'(prog_rd_o));
   endtask

   // register operands land in the bank picked by the status byte
   task automatic t_banks();
      for (int b = 0; b < 4; b++) begin
         @(posedge mclk_i);
         status_byte_i <= 8'(b << 3);
         do_req(MMD_AK_REG, 1'b1, 16'h0007, 8'h3c, 0, 16'(b * 8 + 7), 8'hff,
                8'h00, 1'b0, 8'h00, 1'b0);
      end
      @(posedge mclk_i);
      status_byte_i <= 8'h00;
   endtask

   // watchdog against a hung run
   initial begin
      #200000;
      err_total++;
      $display("ERROR watchdog expected done seen running");
      final_report();
   end

   // main sequence
   initial begin
      err_total     = 0;
      n_checks      = 0;
      reset_i       = 1'b1;
      fetch_i       = 1'b0;
      pc_load_i     = 1'b0;
      pc_load_val_i = 16'h0000;
      irq_accept_i  = 1'b0;
      irq_num_i     = 3'h0;
      prog_rdata_i  = 8'h00;
      req_valid_i   = 1'b0;
      req_i         = '0;
      status_byte_i = 8'h00;
      iram_rdata_i  = 8'h00;
      sfr_rdata_i   = 8'h00;
      sfr_hit_i     = 1'b0;
      aux_rdata_i   = 8'h00;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      #1;
      chk("pc_after_reset", 16'h0000, pc_o);
      fetch_at(16'h0100, 8'ha5, 1'b0);
      fetch_at(16'hf7ff, 8'h3c, 1'b0);
      fetch_at(16'hf800, 8'h3c, 1'b1);
      t_vectors();
      t_reset();
      do_req(MMD_AK_DIRECT, 1'b0, 16'h0000, 8'h00, 0, 16'h0000, 8'hff,
             8'h11, 1'b0, 8'h11, 1'b0);
      do_req(MMD_AK_DIRECT, 1'b0, 16'h007f, 8'h00, 0, 16'h007f, 8'hff,
             8'h22, 1'b0, 8'h22, 1'b0);
      do_req(MMD_AK_DIRECT, 1'b0, 16'h0080, 8'h00, 1, 16'h0080, 8'hff,
             8'h5a, 1'b1, 8'h5a, 1'b0);
      do_req(MMD_AK_DIRECT, 1'b1, 16'h00ff, 8'h66, 1, 16'h00ff, 8'hff,
             8'h00, 1'b1, 8'h00, 1'b0);
      do_req(MMD_AK_DIRECT, 1'b0, 16'h0091, 8'h00, 1, 16'h0091, 8'hff,
             8'h77, 1'b0, 8'h00, 1'b0);
      do_req(MMD_AK_INDIRECT, 1'b0, 16'h0080, 8'h00, 0, 16'h0080, 8'hff,
             8'h33, 1'b1, 8'h33, 1'b0);
      do_req(MMD_AK_INDIRECT, 1'b1, 16'h00ff, 8'h44, 0, 16'h00ff, 8'hff,
             8'h00, 1'b0, 8'h00, 1'b0);
      t_banks();
      do_req(MMD_AK_BIT, 1'b1, 16'h000a, 8'h01, 0, 16'h0021, 8'h04,
             8'h00, 1'b0, 8'h00, 1'b0);
      do_req(MMD_AK_BIT, 1'b1, 16'h007f, 8'h00, 0, 16'h002f, 8'h80,
             8'h00, 1'b0, 8'h00, 1'b0);
      do_req(MMD_AK_BIT, 1'b0, 16'h000a, 8'h00, 0, 16'h0021, 8'hff,
             8'h04, 1'b0, 8'h04, 1'b1);
      do_req(MMD_AK_BIT, 1'b0, 16'h000b, 8'h00, 0, 16'h0021, 8'hff,
             8'h04, 1'b0, 8'h04, 1'b0);
      do_req(MMD_AK_BIT, 1'b1, 16'h0093, 8'h01, 1, 16'h0090, 8'h08,
             8'h00, 1'b1, 8'h00, 1'b0);
      do_req(MMD_AK_BIT, 1'b1, 16'h00ff, 8'h01, 1, 16'h00f8, 8'h80,
             8'h00, 1'b1, 8'h00, 1'b0);
      do_req(MMD_AK_AUX, 1'b0, 16'h0000, 8'h00, 2, 16'h0000, 8'hff,
             8'h9e, 1'b0, 8'h9e, 1'b0);
      do_req(MMD_AK_AUX, 1'b1, 16'h3fff, 8'h5c, 2, 16'h3fff, 8'hff,
             8'h00, 1'b0, 8'h00, 1'b0);
      do_req(MMD_AK_AUX, 1'b0, 16'h4000, 8'h00, 3, 16'h0000, 8'hff,
             8'h00, 1'b0, 8'h00, 1'b0);
      final_report();
   end
endmodule

`default_nettype wire
